// *** jlr_params.svh ***
// Constants for the jump-and-link-register unit.
`ifndef JLR_PARAMS_SVH
`define JLR_PARAMS_SVH

// ----------------------------------------------------------------
// Instruction fields
// ----------------------------------------------------------------
`define JLR_OPC_HI 31
`define JLR_OPC_LO 26
`define JLR_SRC_HI 25
`define JLR_SRC_LO 21
`define JLR_DST_HI 15
`define JLR_DST_LO 11
`define JLR_HINT_HI 10
`define JLR_HINT_LO 6
`define JLR_BARRIER_BIT 10
`define JLR_FN_HI 5
`define JLR_FN_LO 0
`define JLR_OPC_SPECIAL 6'h00
`define JLR_FN_JALR 6'h09
`define JLR_HINT_NONE 5'h00

// ----------------------------------------------------------------
// Datapath constants
// ----------------------------------------------------------------
`define JLR_LINK_OFS 32'h0000_0008
`define JLR_HAZ_W 8
`define JLR_HAZ_NONE 8'h00

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define JLR_ADR_CTRL 8'h00
`define JLR_ADR_STATUS 8'h04
`define JLR_ADR_MASK 8'h08
`define JLR_ADR_TARGET 8'h0C
`define JLR_CTRL_COMP 0
`define JLR_CTRL_REL2 1
`define JLR_EV_DONE 0
`define JLR_EV_ADDRERR 1
`define JLR_EV_SAMEREG 2
`define JLR_EV_RSVD 3
`define JLR_EV_W 4
`define JLR_CTRL_RST 2'h2
`define JLR_EV_NONE 4'h0
`define JLR_WORD_ZERO 32'h0000_0000

`endif

// *** jlr_pkg.sv ***
// Types shared by the jump-and-link-register unit.
package jlr_pkg;
   typedef enum logic {JLR_IDLE, JLR_SLOT} jlr_state_t;

   typedef struct packed {
      logic en;
      logic [4:0] addr;
      logic [31:0] data;
   } jlr_reg_wr_t;

   typedef struct packed {
      logic valid;
      logic [31:0] target;
      logic isaBit;
      logic addrErr;
   } jlr_redir_t;
endpackage

// *** jlr_target_check.sv ***
// Target formation and deferred alignment check for a register jump.
`include "jlr_params.svh"
module jlr_target_check
   import jlr_pkg::*;
(
   input wire logic [31:0] srcVal,
   input wire logic compPresent,
   output logic [31:0] target,
   output logic isaBit,
   output logic addrErr
);
   // ----------------------------------------------------------------
   // Target and mode bit
   // ----------------------------------------------------------------
   always_comb begin
      target = {srcVal[31:1], 1'b0};
      isaBit = compPresent & srcVal[0];
      // The error is only reported; the fetch stage raises it when it fetches the target.
      if (compPresent) begin
         addrErr = ~srcVal[0] & srcVal[1];
      end else begin
         addrErr = srcVal[0] | srcVal[1];
      end
   end
endmodule // jlr_target_check

// *** jlr_unit.sv ***
// Jump-and-link-register execution unit with hazard-barrier variant.
// Operation
// - Link register gets jump address plus eight.
// - Delay slot retires before the new PC.
// - Target bit zero is forced to zero.
// - Mode bit loads from source bit zero.
// - Plain set: low two bits nonzero, error.
// - Compressed set: bit0 zero, bit1 one, error.
// - First release: hint must be zero.
// - Instruction bit ten selects the barrier.
// - Barrier clears hazards before target fetch.
// - Barrier legal in every operating mode.
// - Delay slot hazards are not cleared.
//
// Added by the designer: the address map and the strobed register port.
`include "jlr_params.svh"
module jlr_unit
   import jlr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic issueValid,
   input wire logic [31:0] instrWord,
   input wire logic [31:0] instrPc,
   input wire logic [31:0] srcValue,
   input wire logic slotRetire,
   input wire logic [`JLR_HAZ_W-1:0] hazardPending,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [31:0] regRdData,
   output logic [4:0] targetSourceField,
   output logic busy,
   output jlr_reg_wr_t linkWrite,
   output jlr_redir_t redirect,
   output logic [`JLR_HAZ_W-1:0] hazardClear,
   output logic rsvdInstr,
   output logic irq
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   jlr_state_t stateFf, nxt_stateFf;
   logic [31:0] srcFf, nxt_srcFf;
   logic barrierFf, nxt_barrierFf;
   logic [`JLR_HAZ_W-1:0] hazSnapFf, nxt_hazSnapFf;
   jlr_reg_wr_t linkFf, nxt_linkFf;
   jlr_redir_t redirFf, nxt_redirFf;
   logic [`JLR_HAZ_W-1:0] hazClrFf, nxt_hazClrFf;
   logic rsvdFf, nxt_rsvdFf;
   logic [1:0] ctrlFf, nxt_ctrlFf;
   logic [`JLR_EV_W-1:0] statusFf, nxt_statusFf;
   logic [`JLR_EV_W-1:0] maskFf, nxt_maskFf;
   logic [31:0] lastTgtFf, nxt_lastTgtFf;
   logic [31:0] rdDataFf, nxt_rdDataFf;

   logic [31:0] calcTarget;
   logic calcIsa;
   logic calcErr;
   logic isJalr;
   logic accept;
   logic hintBad;
   logic [`JLR_EV_W-1:0] events;
   logic [4:0] dstField;
   logic [4:0] hintField;

   // ----------------------------------------------------------------
   // Target formation
   // ----------------------------------------------------------------
   jlr_target_check u_check (
      .srcVal(srcFf),
      .compPresent(ctrlFf[`JLR_CTRL_COMP]),
      .target(calcTarget),
      .isaBit(calcIsa),
      .addrErr(calcErr)
   );

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   always_comb begin
      targetSourceField = instrWord[`JLR_SRC_HI:`JLR_SRC_LO];
      dstField = instrWord[`JLR_DST_HI:`JLR_DST_LO];
      hintField = instrWord[`JLR_HINT_HI:`JLR_HINT_LO];
      // No privilege term: the barrier form is accepted in any mode.
      isJalr = (instrWord[`JLR_OPC_HI:`JLR_OPC_LO] == `JLR_OPC_SPECIAL) &&
               (instrWord[`JLR_FN_HI:`JLR_FN_LO] == `JLR_FN_JALR);
      accept = issueValid && isJalr && (stateFf == JLR_IDLE);
      hintBad = ~ctrlFf[`JLR_CTRL_REL2] && (hintField != `JLR_HINT_NONE);
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb begin
      nxt_stateFf = stateFf;
      nxt_srcFf = srcFf;
      nxt_barrierFf = barrierFf;
      nxt_hazSnapFf = hazSnapFf;
      nxt_linkFf = '0;
      nxt_redirFf = '0;
      nxt_hazClrFf = `JLR_HAZ_NONE;
      nxt_rsvdFf = 1'b0;
      nxt_lastTgtFf = lastTgtFf;
      events = `JLR_EV_NONE;
      case (stateFf)
         JLR_IDLE: begin
            if (accept && hintBad) begin
               nxt_rsvdFf = 1'b1;
               events[`JLR_EV_RSVD] = 1'b1;
            end else if (accept) begin
               // The target is held apart so a link to the same register cannot alter it.
               nxt_srcFf = srcValue;
               nxt_barrierFf = ctrlFf[`JLR_CTRL_REL2] & instrWord[`JLR_BARRIER_BIT];
               nxt_hazSnapFf = hazardPending;
               nxt_linkFf.en = 1'b1;
               nxt_linkFf.addr = dstField;
               nxt_linkFf.data = instrPc + `JLR_LINK_OFS;
               events[`JLR_EV_SAMEREG] = (dstField == targetSourceField);
               nxt_stateFf = JLR_SLOT;
            end
         end
         JLR_SLOT: begin
            if (slotRetire) begin
               nxt_redirFf.valid = 1'b1;
               nxt_redirFf.target = calcTarget;
               nxt_redirFf.isaBit = calcIsa;
               nxt_redirFf.addrErr = calcErr;
               nxt_hazClrFf = barrierFf ? hazSnapFf : `JLR_HAZ_NONE;
               nxt_lastTgtFf = calcTarget;
               events[`JLR_EV_DONE] = 1'b1;
               events[`JLR_EV_ADDRERR] = calcErr;
               nxt_stateFf = JLR_IDLE;
            end
         end
         default: begin
            nxt_stateFf = JLR_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   always_comb begin
      nxt_ctrlFf = ctrlFf;
      nxt_maskFf = maskFf;
      nxt_rdDataFf = `JLR_WORD_ZERO;
      // A new event in the clearing read's cycle survives it.
      nxt_statusFf = statusFf | events;
      if (regWrEn) begin
         if (regAddr == `JLR_ADR_CTRL) begin
            nxt_ctrlFf = regWrData[1:0];
         end else if (regAddr == `JLR_ADR_MASK) begin
            nxt_maskFf = regWrData[`JLR_EV_W-1:0];
         end
      end
      if (regRdEn) begin
         if (regAddr == `JLR_ADR_CTRL) begin
            nxt_rdDataFf = {30'h0000_0000, ctrlFf};
         end else if (regAddr == `JLR_ADR_STATUS) begin
            nxt_rdDataFf = {28'h000_0000, statusFf};
            nxt_statusFf = events;
         end else if (regAddr == `JLR_ADR_MASK) begin
            nxt_rdDataFf = {28'h000_0000, maskFf};
         end else if (regAddr == `JLR_ADR_TARGET) begin
            nxt_rdDataFf = lastTgtFf;
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         stateFf <= JLR_IDLE;
         srcFf <= `JLR_WORD_ZERO;
         barrierFf <= 1'b0;
         hazSnapFf <= `JLR_HAZ_NONE;
         linkFf <= '0;
         redirFf <= '0;
         hazClrFf <= `JLR_HAZ_NONE;
         rsvdFf <= 1'b0;
         ctrlFf <= `JLR_CTRL_RST;
         statusFf <= `JLR_EV_NONE;
         maskFf <= `JLR_EV_NONE;
         lastTgtFf <= `JLR_WORD_ZERO;
         rdDataFf <= `JLR_WORD_ZERO;
      end else begin
         stateFf <= nxt_stateFf;
         srcFf <= nxt_srcFf;
         barrierFf <= nxt_barrierFf;
         hazSnapFf <= nxt_hazSnapFf;
         linkFf <= nxt_linkFf;
         redirFf <= nxt_redirFf;
         hazClrFf <= nxt_hazClrFf;
         rsvdFf <= nxt_rsvdFf;
         ctrlFf <= nxt_ctrlFf;
         statusFf <= nxt_statusFf;
         maskFf <= nxt_maskFf;
         lastTgtFf <= nxt_lastTgtFf;
         rdDataFf <= nxt_rdDataFf;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_comb begin
      busy = (stateFf != JLR_IDLE);
      linkWrite = linkFf;
      redirect = redirFf;
      hazardClear = hazClrFf;
      rsvdInstr = rsvdFf;
      regRdData = rdDataFf;
      irq = |(statusFf & maskFf);
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_link_return_value: assert property (
      accept && !hintBad |=> linkWrite.en && linkWrite.data == $past(instrPc) + `JLR_LINK_OFS)
      else $error("link value is not jump address plus eight");

   a_slot_then_redirect: assert property (
      redirect.valid |-> $past(slotRetire) && $past(stateFf) == JLR_SLOT && !busy)
      else $error("redirect without a retired delay slot");

   a_target_low_zero: assert property (
      redirect.valid |-> redirect.target == {$past(srcFf[31:1]), 1'b0})
      else $error("target bit zero not cleared");

   a_mode_bit_load: assert property (
      redirect.valid && $past(ctrlFf[`JLR_CTRL_COMP]) |-> redirect.isaBit == $past(srcFf[0]))
      else $error("mode bit not taken from source bit zero");

   a_plain_align_err: assert property (
      redirect.valid && !$past(ctrlFf[`JLR_CTRL_COMP]) |->
      redirect.addrErr == (|$past(srcFf[1:0])))
      else $error("plain alignment error wrong");

   a_comp_align_err: assert property (
      redirect.valid && $past(ctrlFf[`JLR_CTRL_COMP]) |->
      redirect.addrErr == (!$past(srcFf[0]) && $past(srcFf[1])))
      else $error("compressed alignment error wrong");

   a_hint_first_rel: assert property (
      accept && hintBad |=> rsvdInstr && !linkWrite.en && !busy)
      else $error("nonzero hint accepted in first release");

   a_barrier_clear: assert property (
      redirect.valid |-> hazardClear == (barrierFf ? hazSnapFf : `JLR_HAZ_NONE))
      else $error("barrier clear does not match captured hazards");

   a_slot_hazard_kept: assert property (
      redirect.valid |-> (hazardClear & ~hazSnapFf) == `JLR_HAZ_NONE)
      else $error("delay slot hazard was cleared");

   a_src_capture: assert property (
      accept && !hintBad |=> srcFf == $past(srcValue))
      else $error("source not captured at issue");

   a_barrier_select: assert property (
      accept && !hintBad |=> barrierFf == $past(ctrlFf[`JLR_CTRL_REL2] &
                                                instrWord[`JLR_BARRIER_BIT]))
      else $error("barrier bit decode wrong");

   a_link_dest_field: assert property (
      accept && !hintBad |=> linkWrite.addr == $past(instrWord[`JLR_DST_HI:`JLR_DST_LO]))
      else $error("link register index not taken from the instruction");

   a_busy_refuse_offer: assert property (
      busy && issueValid |=> !linkWrite.en && !rsvdInstr)
      else $error("offer accepted while waiting for the delay slot");

   a_link_one_pulse: assert property (
      linkWrite.en |=> !linkWrite.en)
      else $error("link write longer than one cycle");

   a_redirect_one_pulse: assert property (
      redirect.valid |=> !redirect.valid)
      else $error("redirect longer than one cycle");

   a_done_status_set: assert property (
      redirect.valid |-> statusFf[`JLR_EV_DONE])
      else $error("finished jump not recorded in status");

   a_plain_isa_zero: assert property (
      redirect.valid && !$past(ctrlFf[`JLR_CTRL_COMP]) |-> !redirect.isaBit)
      else $error("mode bit set without compressed set");

   a_clear_with_jump: assert property (
      hazardClear != `JLR_HAZ_NONE |-> redirect.valid)
      else $error("hazards cleared outside a jump");

   c_plain_jump: cover property (accept ##[1:10] redirect.valid && !barrierFf);
   c_barrier_jump: cover property (redirect.valid && hazardClear != `JLR_HAZ_NONE);
   c_align_error: cover property (redirect.valid && redirect.addrErr);
   c_reserved_hint: cover property (rsvdInstr);
   c_same_reg: cover property (accept && !hintBad && dstField == targetSourceField);
endmodule // jlr_unit

// *** jlr_fetch_model.sv ***
// Fetch-side partner: general register file and delay-slot completion.
module jlr_fetch_model
   import jlr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [4:0] targetSourceField,
   input wire jlr_reg_wr_t linkWrite,
   input wire logic busy,
   input wire logic [2:0] slotDelay,
   input wire logic pokeEn,
   input wire logic [4:0] pokeAddr,
   input wire logic [31:0] pokeData,
   output logic [31:0] srcValue,
   output logic slotRetire
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] regFile [32];
   logic [3:0] waitCnt = 4'h0;
   initial slotRetire = 1'b0;
   assign srcValue = regFile[targetSourceField];
   // -----------------------------------------------------------------
   // Register file and slot timing
   // -----------------------------------------------------------------
   // The link write lands in the register file, so a late read of the
   // source would see the return address instead of the target.
   always @(posedge sys_clk) begin
      if (pokeEn) begin
         regFile[pokeAddr] <= pokeData;
      end
      if (linkWrite.en) begin
         regFile[linkWrite.addr] <= linkWrite.data;
      end
      if (rst || !busy || slotRetire) begin
         waitCnt <= 4'h0;
         slotRetire <= 1'b0;
      end else if (waitCnt == {1'b0, slotDelay}) begin
         slotRetire <= 1'b1;
      end else begin
         waitCnt <= waitCnt + 4'h1;
      end
   end
endmodule // jlr_fetch_model

// *** tb_jlr_unit.sv ***
// Self-checking bench for the jump-and-link-register unit.
`include "jlr_params.svh"
module tb_jlr_unit
   import jlr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0, rst = 1'b1, issueValid = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
   logic pokeEn = 1'b0, rdPend = 1'b0, slotRetire, busy, rsvdInstr, irq;
   logic [31:0] instrWord = 32'h0000_0000, instrPc = 32'h0000_0000, srcValue, regRdData;
   logic [31:0] regWrData = 32'h0000_0000, pokeData = 32'h0000_0000, lastTgt = 32'h0000_0000;
   logic [7:0] hazardPending = 8'h00, regAddr = 8'h00, hazardClear;
   logic [4:0] targetSourceField, pokeAddr = 5'h00;
   logic [2:0] slotDelay = 3'h0;
   jlr_reg_wr_t linkWrite;
   jlr_redir_t redirect;
   logic [37:0] linkQ[$];
   logic [41:0] redirQ[$];
   logic [31:0] rdQ[$];
   int num_errors = 0, n_compared = 0, rsvdSeen = 0, rsvdExp = 0;
   always #25 sys_clk = ~sys_clk;
   jlr_unit jlr_unit_i (.sys_clk(sys_clk), .rst(rst), .issueValid(issueValid),
      .instrWord(instrWord), .instrPc(instrPc), .srcValue(srcValue), .slotRetire(slotRetire),
      .hazardPending(hazardPending), .regAddr(regAddr), .regWrData(regWrData),
      .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
      .targetSourceField(targetSourceField), .busy(busy), .linkWrite(linkWrite),
      .redirect(redirect), .hazardClear(hazardClear), .rsvdInstr(rsvdInstr), .irq(irq));
   jlr_fetch_model jlr_fetch_model_i (.sys_clk(sys_clk), .rst(rst),
      .targetSourceField(targetSourceField), .linkWrite(linkWrite), .busy(busy),
      .slotDelay(slotDelay), .pokeEn(pokeEn), .pokeAddr(pokeAddr), .pokeData(pokeData),
      .srcValue(srcValue), .slotRetire(slotRetire));
   // -----------------------------------------------------------------
   // Checking and closing
   // -----------------------------------------------------------------
   task automatic chk(input string what, input logic [41:0] seen, input logic [41:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Results are matched against the oldest note; an empty queue yields X and fails.
   always @(posedge sys_clk) begin
      rdPend <= regRdEn;
      if (rdPend) begin
         chk("read data", regRdData, rdQ.size() > 0 ? rdQ.pop_front() : 'x);
      end
      if (linkWrite.en === 1'b1) begin
         chk("link", linkWrite, linkQ.size() > 0 ? linkQ.pop_front() : 'x);
      end
      if (redirect.valid === 1'b1) begin
         chk("redirect", {redirect.target, redirect.isaBit, redirect.addrErr, hazardClear},
             redirQ.size() > 0 ? redirQ.pop_front() : 'x);
      end
      if (rsvdInstr === 1'b1) begin
         rsvdSeen++;
      end
   end
   // -----------------------------------------------------------------
   // Drivers
   // -----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      regAddr <= a;
      regWrData <= d;
      regRdEn <= 1'b0;
      regWrEn <= 1'b1;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rdQ.push_back(e);
      regAddr <= a;
      regWrEn <= 1'b0;
      regRdEn <= 1'b1;
      @(posedge sys_clk);
   endtask
   task automatic waitIdle();
      int k;
      k = 0;
      @(negedge sys_clk);
      while (busy !== 1'b0) begin
         k++;
         if (k > 50) begin
            num_errors++;
            stop_test();
         end
         @(negedge sys_clk);
      end
      @(posedge sys_clk);
   endtask
   task automatic jump(input logic [31:0] iw, input logic [31:0] sv, input logic [1:0] ctl,
                       input logic [2:0] dly);
      logic rsv;
      logic [7:0] hz;
      logic [31:0] pc;
      logic [3:0] st;
      rsv = !ctl[1] && iw[10:6] != 5'h00;
      hz = 8'($urandom());
      pc = $urandom() & 32'hFFFF_FFFC;
      st = rsv ? 4'h8 : {1'b0, iw[25:21] == iw[15:11], ctl[0] ? sv[1:0] == 2'b10 : |sv[1:0], 1'b1};
      wr(`JLR_ADR_CTRL, {30'h0, ctl});
      regWrEn <= 1'b0;
      pokeEn <= 1'b1;
      pokeAddr <= iw[25:21];
      pokeData <= sv;
      slotDelay <= dly;
      @(posedge sys_clk);
      pokeEn <= 1'b0;
      issueValid <= 1'b1;
      instrWord <= iw;
      instrPc <= pc;
      hazardPending <= hz;
      rsvdExp += rsv;
      if (!rsv) begin
         lastTgt = {sv[31:1], 1'b0};
         linkQ.push_back({1'b1, iw[15:11], pc + `JLR_LINK_OFS});
         redirQ.push_back({lastTgt, ctl[0] & sv[0], st[1], ctl[1] & iw[10] ? hz : 8'h00});
      end
      @(posedge sys_clk);
      hazardPending <= ~hz;
      issueValid <= !rsv;
      @(posedge sys_clk);
      issueValid <= 1'b0;
      waitIdle();
      repeat (2) @(posedge sys_clk);
      chk("irq", irq, |(st & 4'h6));
      rd(`JLR_ADR_STATUS, {28'h0, st});
      rd(`JLR_ADR_TARGET, lastTgt);
      chk("irq cleared", irq, 0);
   endtask
   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      logic [4:0] s;
      logic [4:0] d;
      logic [31:0] sv;
      void'($urandom(32'hc657));
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      rd(`JLR_ADR_CTRL, 32'h0000_0002);
      rd(`JLR_ADR_STATUS, 32'h0000_0000);
      rd(8'h10, 32'h0000_0000);
      wr(8'h10, 32'hFFFF_FFFF);
      wr(`JLR_ADR_TARGET, 32'h1234_5678);
      rd(8'h10, 32'h0000_0000);
      rd(`JLR_ADR_TARGET, 32'h0000_0000);
      wr(`JLR_ADR_MASK, 32'h0000_0006);
      rd(`JLR_ADR_MASK, 32'h0000_0006);
      for (int i = 0; i < 16; i++) begin
         s = 5'($urandom_range(1, 30));
         d = (i == 6) ? s : ((i % 4 == 0) ? 5'd31 : ~s);
         sv = $urandom();
         sv[0] = sv[0] & i[0];
         jump({6'h00, s, 5'h00, d, i[2], 3'h0, i[3], 6'h09}, sv, i[1:0], i[2:0]);
      end
      regRdEn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk("reserved count", rsvdSeen, rsvdExp);
      chk("pending notes", linkQ.size() + redirQ.size() + rdQ.size(), 0);
      stop_test();
   end
endmodule // tb_jlr_unit
